/* File: rtl/strap_cfg.sv */
// strap capture, mode decode and multi-function pin routing with an apb register slave
`timescale 1ns/1ps
//
// Notes on behaviour
// - use bit 1 gives gpio, 0 native
// - gpio direction bit 1 input, 0 output
// - boot destination 11 serial, 00 lpc
// - software overrides boot destination bits 11:10
// - cipher strap 1 enables transport cipher suite
// - override strap 1 bypasses descriptor security
// - no-reboot strap 1 suppresses watchdog reboot
// - top-swap strap 0 inverts selected address line
// - self-test strap 1 runs built-in self test
// - service-processor strap 1 selects that boot
// - trust straps 1 enable platform and agent
// - safe boot strap 1 selects safe boot
// - debug strap low selects debug mode
// - memory type strap 1 ddr4, 0 ddr3
// - three straps give the socket identity
// - lan straps 00 off, 01 port0, 11 both
// - nvm security strap 1 enables security
// - lan power strap 1 drops s5 lan, manageability
// - supply strap 1 selects combined supply mode
// - management link serdes by default, sgmii optional
module strap_cfg
   import strap_cfg_pkg::*;
#(
   parameter int unsigned NUM_PINS = 32
) (
   input  wire logic                core_clk_i,
   input  wire logic                resetn_i,
   // apb slave
   input  wire logic                psel_i,
   input  wire logic                penable_i,
   input  wire logic                pwrite_i,
   input  wire logic [ADDR_W-1:0]   paddr_i,
   input  wire logic [DATA_W-1:0]   pwdata_i,
   input  wire logic [3:0]          pstrb_i,
   output logic      [DATA_W-1:0]   prdata_o,
   output logic                     pready_o,
   output logic                     pslverr_o,
   // straps
   input  wire logic                boot_dest_strap_lo_i,
   input  wire logic                boot_dest_strap_hi_i,
   input  wire logic                cipher_suite_strap_i,
   input  wire logic                manufacturing_override_strap_i,
   input  wire logic                no_reboot_strap_i,
   input  wire logic                top_swap_strap_i,
   input  wire logic                self_test_strap_i,
   input  wire logic                service_processor_boot_strap_i,
   input  wire logic                trusted_platform_strap_i,
   input  wire logic                trusted_agent_strap_i,
   input  wire logic                safe_boot_strap_i,
   input  wire logic                debug_strap_n_i,
   input  wire logic                memory_type_strap_i,
   input  wire logic [2:0]          socket_identity_straps_i,
   input  wire logic                lan_port_enable_strap_0_i,
   input  wire logic                lan_port_enable_strap_1_i,
   input  wire logic                nvm_security_strap_i,
   input  wire logic                lan_power_state_strap_i,
   input  wire logic                supply_mode_strap_i,
   // multi-function pins
   input  wire logic [NUM_PINS-1:0] pad_i,
   output logic      [NUM_PINS-1:0] pad_o,
   output logic      [NUM_PINS-1:0] pad_oe_o,
   input  wire logic [NUM_PINS-1:0] native_out_i,
   input  wire logic [NUM_PINS-1:0] native_oe_i,
   output logic      [NUM_PINS-1:0] native_in_o,
   // decoded modes
   output logic                     strap_valid_o,
   output logic                     boot_serial_o,
   output logic                     boot_lpc_o,
   output logic                     cipher_suite_en_o,
   output logic                     descriptor_security_en_o,
   output logic                     watchdog_reboot_en_o,
   output logic      [4:0]          top_swap_mask_o,
   output logic                     self_test_en_o,
   output logic                     service_boot_o,
   output logic                     trusted_platform_o,
   output logic                     trusted_agent_o,
   output logic                     safe_boot_o,
   output logic                     debug_mode_o,
   output logic                     mem_ddr4_o,
   output logic      [2:0]          socket_id_o,
   output logic                     lan_port0_en_o,
   output logic                     lan_port1_en_o,
   output logic                     manageability_en_o,
   output logic                     nvm_security_en_o,
   output logic                     lan_s5_avail_o,
   output logic                     combined_supply_o,
   output logic                     mgmt_serdes_mode_o
);

   typedef struct packed {
      logic                captured;
      logic [STRAP_W-1:0]  straps;
      logic [1:0]          boot_dest;
      logic                serdes;
      logic [2:0]          swap_size;
      logic [NUM_PINS-1:0] use_sel;
      logic [NUM_PINS-1:0] dir_sel;
      logic [NUM_PINS-1:0] gpio_out;
      logic [NUM_PINS-1:0] gpio_in;
      logic [NUM_PINS-1:0] pad_out;
      logic [NUM_PINS-1:0] pad_oe;
      logic [NUM_PINS-1:0] native_in;
      logic [MODE_W-1:0]   mode;
      logic [4:0]          swap_mask;
      logic                pready;
      logic [DATA_W-1:0]   prdata;
      logic                pslverr;
   } state_t;

   state_t st;
   state_t next_st;

   logic [STRAP_W-1:0] sampled_straps;
   logic               wr_take;
   logic               rd_take;

   // byte-lane merge of an apb write into a register value
   function automatic logic [DATA_W-1:0] merge_bytes(input logic [DATA_W-1:0] old_val,
                                                      input logic [DATA_W-1:0] wdata,
                                                      input logic [3:0]        strb);
      logic [DATA_W-1:0] res;
      res = old_val;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = wdata[b*8 +: 8];
         end
      end
      return res;
   endfunction : merge_bytes

   function automatic logic [DATA_W-1:0] widen_pins(input logic [NUM_PINS-1:0] v);
      logic [DATA_W-1:0] res;
      res = '0;
      res[NUM_PINS-1:0] = v;
      return res;
   endfunction : widen_pins

   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      return (a == OFS_PIN_USE) || (a == OFS_PIN_DIR) || (a == OFS_PIN_OUT) || (a == OFS_PIN_IN) ||
             (a == OFS_STRAP_RAW) || (a == OFS_MODE_CFG) || (a == OFS_MODE_STAT) || (a == OFS_BOOT_DEST);
   endfunction : is_mapped

   assign sampled_straps = {supply_mode_strap_i, lan_power_state_strap_i, nvm_security_strap_i,
                            lan_port_enable_strap_1_i, lan_port_enable_strap_0_i, socket_identity_straps_i,
                            memory_type_strap_i, debug_strap_n_i, safe_boot_strap_i, trusted_agent_strap_i,
                            trusted_platform_strap_i, service_processor_boot_strap_i, self_test_strap_i,
                            top_swap_strap_i, no_reboot_strap_i, manufacturing_override_strap_i,
                            cipher_suite_strap_i, boot_dest_strap_hi_i, boot_dest_strap_lo_i};

   // write lands on the edge that sees pready high, read data is staged one cycle earlier
   assign wr_take = psel_i && penable_i && st.pready && pwrite_i;
   assign rd_take = psel_i && penable_i && !st.pready;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic [DATA_W-1:0] cfg_word;
      logic [DATA_W-1:0] dest_word;
      logic [STRAP_W-1:0] s;
      logic [DATA_W-1:0] pin_word;
      cfg_word  = '0;
      dest_word = '0;
      pin_word  = '0;
      s         = '0;
      next_st   = st;

      // one-shot capture keeps later pin activity out of every mode
      if (!st.captured) begin
         next_st.captured  = 1'b1;
         next_st.straps    = sampled_straps;
         next_st.boot_dest = {sampled_straps[S_DEST_HI], sampled_straps[S_DEST_LO]};
      end

      // register writes
      if (wr_take) begin
         unique case (paddr_i)
            OFS_PIN_USE: begin
               pin_word         = merge_bytes(widen_pins(st.use_sel), pwdata_i, pstrb_i);
               next_st.use_sel  = pin_word[NUM_PINS-1:0];
            end
            OFS_PIN_DIR: begin
               pin_word         = merge_bytes(widen_pins(st.dir_sel), pwdata_i, pstrb_i);
               next_st.dir_sel  = pin_word[NUM_PINS-1:0];
            end
            OFS_PIN_OUT: begin
               pin_word         = merge_bytes(widen_pins(st.gpio_out), pwdata_i, pstrb_i);
               next_st.gpio_out = pin_word[NUM_PINS-1:0];
            end
            OFS_MODE_CFG: begin
               cfg_word          = merge_bytes({28'h0000000, st.swap_size, st.serdes}, pwdata_i, pstrb_i);
               next_st.serdes    = cfg_word[CFG_SERDES];
               next_st.swap_size = cfg_word[CFG_SWAP_LSB +: 3];
            end
            OFS_BOOT_DEST: begin
               dest_word         = merge_bytes({20'h00000, st.boot_dest, 10'h000}, pwdata_i, pstrb_i);
               next_st.boot_dest = dest_word[BOOT_DEST_LSB +: 2];
            end
            default: begin
            end
         endcase
      end

      // apb answer: one wait state, error on unmapped offsets
      next_st.pready  = rd_take;
      next_st.pslverr = rd_take && !is_mapped(paddr_i);
      if (rd_take) begin
         unique case (paddr_i)
            OFS_PIN_USE:   next_st.prdata = widen_pins(st.use_sel);
            OFS_PIN_DIR:   next_st.prdata = widen_pins(st.dir_sel);
            OFS_PIN_OUT:   next_st.prdata = widen_pins(st.gpio_out);
            OFS_PIN_IN:    next_st.prdata = widen_pins(st.gpio_in);
            OFS_STRAP_RAW: next_st.prdata = {11'h000, st.straps};
            OFS_MODE_CFG:  next_st.prdata = {28'h0000000, st.swap_size, st.serdes};
            OFS_MODE_STAT: next_st.prdata = {9'h000, st.mode};
            OFS_BOOT_DEST: next_st.prdata = {20'h00000, st.boot_dest, 10'h000};
            default:       next_st.prdata = '0;
         endcase
      end else begin
         next_st.prdata = '0;
      end

      // pin routing
      next_st.pad_out   = (st.use_sel & st.gpio_out) | (~st.use_sel & native_out_i);
      next_st.pad_oe    = (st.use_sel & ~st.dir_sel) | (~st.use_sel & native_oe_i);
      next_st.gpio_in   = st.use_sel & pad_i;
      next_st.native_in = ~st.use_sel & pad_i;

      // mode decode from the held straps
      s = next_st.straps;
      next_st.mode                = '0;
      next_st.swap_mask           = '0;
      if (next_st.captured) begin
         next_st.mode[M_BOOT_SERIAL] = (next_st.boot_dest == DEST_SERIAL);
         next_st.mode[M_BOOT_LPC]    = (next_st.boot_dest == DEST_LPC);
         next_st.mode[M_BOOT_RSVD]   = (next_st.boot_dest != DEST_SERIAL) && (next_st.boot_dest != DEST_LPC);
         next_st.mode[M_CIPHER]      = s[S_CIPHER];
         next_st.mode[M_DESC_SEC]    = !s[S_MFG];
         next_st.mode[M_WDT_REBOOT]  = !s[S_NO_REBOOT];
         next_st.mode[M_SWAP_ON]     = !s[S_TOP_SWAP];
         // block sizes past the top line fall back to the default line
         if (!s[S_TOP_SWAP]) begin
            next_st.swap_mask = (next_st.swap_size > SWAP_SIZE_MAX) ? 5'h01
                                : 5'((5'h01 << next_st.swap_size));
         end
         next_st.mode[M_SELF_TEST]   = s[S_SELF_TEST];
         next_st.mode[M_SVC_BOOT]    = s[S_SVC_BOOT];
         next_st.mode[M_TRUST_PLAT]  = s[S_TRUST_PLAT];
         next_st.mode[M_TRUST_AGENT] = s[S_TRUST_AGENT];
         next_st.mode[M_SAFE_BOOT]   = s[S_SAFE_BOOT];
         next_st.mode[M_DEBUG]       = !s[S_DEBUG_N];
         next_st.mode[M_DDR4]        = s[S_MEM_TYPE];
         // reserved code 10 leaves both ports off
         next_st.mode[M_LAN0]        = s[S_LAN0];
         next_st.mode[M_LAN1]        = s[S_LAN0] && s[S_LAN1];
         next_st.mode[M_LAN_RSVD]    = !s[S_LAN0] && s[S_LAN1];
         next_st.mode[M_MANAGE]      = s[S_LAN0] && !s[S_LAN_PWR];
         next_st.mode[M_NVM_SEC]     = s[S_NVM_SEC];
         next_st.mode[M_LAN_S5]      = !s[S_LAN_PWR];
         next_st.mode[M_SUPPLY]      = s[S_SUPPLY];
         next_st.mode[M_SERDES]      = next_st.serdes;
         next_st.mode[M_VALID]       = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         st           <= '0;
         st.serdes    <= SERDES_RST;
         st.swap_size <= SWAP_SIZE_RST;
         st.use_sel   <= {NUM_PINS{USE_RST}};
         st.dir_sel   <= {NUM_PINS{DIR_RST}};
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign prdata_o                 = st.prdata;
   assign pready_o                 = st.pready;
   assign pslverr_o                = st.pslverr;
   assign pad_o                    = st.pad_out;
   assign pad_oe_o                 = st.pad_oe;
   assign native_in_o              = st.native_in;
   assign strap_valid_o            = st.mode[M_VALID];
   assign boot_serial_o            = st.mode[M_BOOT_SERIAL];
   assign boot_lpc_o               = st.mode[M_BOOT_LPC];
   assign cipher_suite_en_o        = st.mode[M_CIPHER];
   assign descriptor_security_en_o = st.mode[M_DESC_SEC];
   assign watchdog_reboot_en_o     = st.mode[M_WDT_REBOOT];
   assign top_swap_mask_o          = st.swap_mask;
   assign self_test_en_o           = st.mode[M_SELF_TEST];
   assign service_boot_o           = st.mode[M_SVC_BOOT];
   assign trusted_platform_o       = st.mode[M_TRUST_PLAT];
   assign trusted_agent_o          = st.mode[M_TRUST_AGENT];
   assign safe_boot_o              = st.mode[M_SAFE_BOOT];
   assign debug_mode_o             = st.mode[M_DEBUG];
   assign mem_ddr4_o               = st.mode[M_DDR4];
   assign socket_id_o              = st.straps[S_SOCKET_LSB +: 3];
   assign lan_port0_en_o           = st.mode[M_LAN0];
   assign lan_port1_en_o           = st.mode[M_LAN1];
   assign manageability_en_o       = st.mode[M_MANAGE];
   assign nvm_security_en_o        = st.mode[M_NVM_SEC];
   assign lan_s5_avail_o           = st.mode[M_LAN_S5];
   assign combined_supply_o        = st.mode[M_SUPPLY];
   assign mgmt_serdes_mode_o       = st.mode[M_SERDES];

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);

   AST_GPIO_ROUTE:
   assert property ($past(resetn_i) |-> ((pad_o ^ $past(st.gpio_out)) & $past(st.use_sel)) == '0)
      else $error("gpio pin not driven from gpio output");

   AST_NATIVE_ROUTE:
   assert property ($past(resetn_i) |-> ((pad_o ^ $past(native_out_i)) & ~$past(st.use_sel)) == '0)
      else $error("native pin not driven from native function");

   AST_GPIO_DIR:
   assert property ($past(resetn_i) |-> ((pad_oe_o ^ ~$past(st.dir_sel)) & $past(st.use_sel)) == '0)
      else $error("gpio enable does not follow direction bit");

   AST_NATIVE_OE:
   assert property ($past(resetn_i) |-> ((pad_oe_o ^ $past(native_oe_i)) & ~$past(st.use_sel)) == '0)
      else $error("native pin enable depends on direction bit");

   AST_BOOT_DECODE:
   assert property (st.captured |-> (boot_serial_o == (st.boot_dest == 2'h3))
                    && (boot_lpc_o == (st.boot_dest == 2'h0)))
      else $error("boot destination decode wrong");

   AST_BOOT_OVERRIDE:
   assert property ((wr_take && paddr_i == OFS_BOOT_DEST && pstrb_i[1] && st.captured)
                    |=> st.boot_dest == $past(pwdata_i[11:10]) ##1 boot_serial_o == (st.boot_dest == 2'h3))
      else $error("boot destination override lost");

   AST_STRAP_CAPTURE:
   assert property ($rose(st.captured) |-> st.straps == $past(sampled_straps) ##1 strap_valid_o)
      else $error("straps not captured at reset release");

   AST_STRAP_HOLD:
   assert property (st.captured && $past(st.captured) |-> $stable(st.straps))
      else $error("captured straps changed");

   AST_NO_REBOOT:
   assert property (strap_valid_o |-> watchdog_reboot_en_o == !st.straps[S_NO_REBOOT])
      else $error("watchdog reboot mode wrong");

   AST_TOP_SWAP:
   assert property (strap_valid_o && !st.straps[S_TOP_SWAP] && st.swap_size == 3'h0 |-> top_swap_mask_o == 5'h01)
      else $error("top swap does not invert default line");

   AST_MANAGE:
   assert property (manageability_en_o |-> lan_port0_en_o && lan_s5_avail_o)
      else $error("manageability on with lan off or s5 unavailable");

   AST_DESC_SEC:
   assert property (strap_valid_o |-> descriptor_security_en_o == !st.straps[S_MFG])
      else $error("descriptor security does not follow override strap");

   AST_DEBUG_MODE:
   assert property (strap_valid_o |-> debug_mode_o == !st.straps[S_DEBUG_N])
      else $error("debug mode does not follow active-low strap");

   AST_LAN_OFF:
   assert property (strap_valid_o && !st.straps[S_LAN0]
                    |-> !lan_port0_en_o && !lan_port1_en_o && !manageability_en_o)
      else $error("lan port or manageability on with port 0 strap low");

   AST_NATIVE_IN:
   assert property ($past(resetn_i) |-> native_in_o == ($past(pad_i) & ~$past(st.use_sel)))
      else $error("native input not routed from pin");

   AST_APB_ANSWER:
   assert property (rd_take |=> pready_o ##1 !pready_o)
      else $error("apb answer not one cycle after access");

   COV_BOOT_WRITE:   cover property (wr_take && paddr_i == OFS_BOOT_DEST);
   COV_UNMAPPED:     cover property (pready_o && pslverr_o);
   COV_SWAP_ACTIVE:  cover property (strap_valid_o && top_swap_mask_o != 5'h00);
   COV_MANAGE:       cover property (manageability_en_o);

endmodule : strap_cfg

/* File: include/strap_cfg_pkg.sv */
// register map, strap layout and reset values of the strap and pin configuration block
package strap_cfg_pkg;

   localparam int unsigned ADDR_W        = 16;
   localparam int unsigned DATA_W        = 32;

   // register byte offsets
   localparam logic [15:0] OFS_PIN_USE   = 16'h0000;
   localparam logic [15:0] OFS_PIN_DIR   = 16'h0004;
   localparam logic [15:0] OFS_PIN_OUT   = 16'h0008;
   localparam logic [15:0] OFS_PIN_IN    = 16'h000C;
   localparam logic [15:0] OFS_STRAP_RAW = 16'h0010;
   localparam logic [15:0] OFS_MODE_CFG  = 16'h0014;
   localparam logic [15:0] OFS_MODE_STAT = 16'h0018;
   localparam logic [15:0] OFS_BOOT_DEST = 16'h3410;

   // boot destination field in its register
   localparam int unsigned BOOT_DEST_LSB = 10;
   localparam logic [1:0]  DEST_SERIAL   = 2'h3;
   localparam logic [1:0]  DEST_LPC      = 2'h0;

   // mode configuration fields and reset values
   localparam int unsigned CFG_SERDES    = 0;
   localparam int unsigned CFG_SWAP_LSB  = 1;
   localparam logic        SERDES_RST    = 1'b1;
   localparam logic [2:0]  SWAP_SIZE_RST = 3'h0;
   localparam logic [2:0]  SWAP_SIZE_MAX = 3'h4;

   // pin configuration reset values: native function, input
   localparam logic        USE_RST       = 1'b0;
   localparam logic        DIR_RST       = 1'b1;

   // captured strap vector layout
   localparam int unsigned STRAP_W       = 21;
   localparam int unsigned S_DEST_LO     = 0;
   localparam int unsigned S_DEST_HI     = 1;
   localparam int unsigned S_CIPHER      = 2;
   localparam int unsigned S_MFG         = 3;
   localparam int unsigned S_NO_REBOOT   = 4;
   localparam int unsigned S_TOP_SWAP    = 5;
   localparam int unsigned S_SELF_TEST   = 6;
   localparam int unsigned S_SVC_BOOT    = 7;
   localparam int unsigned S_TRUST_PLAT  = 8;
   localparam int unsigned S_TRUST_AGENT = 9;
   localparam int unsigned S_SAFE_BOOT   = 10;
   localparam int unsigned S_DEBUG_N     = 11;
   localparam int unsigned S_MEM_TYPE    = 12;
   localparam int unsigned S_SOCKET_LSB  = 13;
   localparam int unsigned S_LAN0        = 16;
   localparam int unsigned S_LAN1        = 17;
   localparam int unsigned S_NVM_SEC     = 18;
   localparam int unsigned S_LAN_PWR     = 19;
   localparam int unsigned S_SUPPLY      = 20;

   // decoded mode status layout
   localparam int unsigned MODE_W        = 23;
   localparam int unsigned M_BOOT_SERIAL = 0;
   localparam int unsigned M_BOOT_LPC    = 1;
   localparam int unsigned M_BOOT_RSVD   = 2;
   localparam int unsigned M_CIPHER      = 3;
   localparam int unsigned M_DESC_SEC    = 4;
   localparam int unsigned M_WDT_REBOOT  = 5;
   localparam int unsigned M_SWAP_ON     = 6;
   localparam int unsigned M_SELF_TEST   = 7;
   localparam int unsigned M_SVC_BOOT    = 8;
   localparam int unsigned M_TRUST_PLAT  = 9;
   localparam int unsigned M_TRUST_AGENT = 10;
   localparam int unsigned M_SAFE_BOOT   = 11;
   localparam int unsigned M_DEBUG       = 12;
   localparam int unsigned M_DDR4        = 13;
   localparam int unsigned M_LAN0        = 14;
   localparam int unsigned M_LAN1        = 15;
   localparam int unsigned M_LAN_RSVD    = 16;
   localparam int unsigned M_MANAGE      = 17;
   localparam int unsigned M_NVM_SEC     = 18;
   localparam int unsigned M_LAN_S5      = 19;
   localparam int unsigned M_SUPPLY      = 20;
   localparam int unsigned M_SERDES      = 21;
   localparam int unsigned M_VALID       = 22;

endpackage : strap_cfg_pkg

/* File: testbench/strap_board_model.sv */
// board strap resistors and pin pulls around the strap block
`timescale 1ns/1ps
module strap_board_model (
   input  wire logic        alt_i,
   input  wire logic [31:0] pin_drv_i,
   input  wire logic [31:0] pin_oe_i,
   input  wire logic [31:0] pull_i,
   output logic      [20:0] strap_o,
   output logic      [31:0] pin_o
);
   // board fit: override strap low, lan straps 11; alt_i turns every strap round
   localparam logic [20:0] FIT = 21'h131CA3;
   assign strap_o = alt_i ? ~FIT : FIT;
   // late-low pins rest on their pulls until driven
   assign pin_o = (pin_drv_i & pin_oe_i) | (pull_i & ~pin_oe_i);
endmodule : strap_board_model

/* File: testbench/testbench.sv */
// apb driven bench for strap capture, mode decode and pin routing
`timescale 1ns/1ps
module testbench import strap_cfg_pkg::*;;
   localparam logic [20:0] FIT = 21'h131CA3;
   logic        core_clk_i = 1'b0, resetn_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, alt = 1'b0;
   logic [15:0] paddr_i = 16'h0000;
   logic [3:0]  pstrb_i = 4'hF;
   logic [31:0] pwdata_i = 32'h0, native_out_i = 32'h3C3C_5A5A, native_oe_i = 32'h0000_FFFF, pull = 32'h0F0F_0F0F;
   logic [31:0] prdata_o, pad_i, pad_o, pad_oe_o, native_in_o;
   logic        pready_o, pslverr_o, strap_valid_o, boot_lpc_o, mgmt_serdes_mode_o;
   logic [4:0]  top_swap_mask_o;
   logic [20:0] st;
   wire  [22:0] mo;
   logic [2:0]  sid;
   int          miscompares = 0, compares = 0, cyc = 0;
   strap_cfg strap_cfg_inst (.*,
      .boot_dest_strap_lo_i(st[0]), .boot_dest_strap_hi_i(st[1]), .cipher_suite_strap_i(st[2]),
      .manufacturing_override_strap_i(st[3]), .no_reboot_strap_i(st[4]), .top_swap_strap_i(st[5]),
      .self_test_strap_i(st[6]), .service_processor_boot_strap_i(st[7]), .trusted_platform_strap_i(st[8]),
      .trusted_agent_strap_i(st[9]), .safe_boot_strap_i(st[10]), .debug_strap_n_i(st[11]),
      .memory_type_strap_i(st[12]), .socket_identity_straps_i(st[15:13]), .lan_port_enable_strap_0_i(st[16]),
      .lan_port_enable_strap_1_i(st[17]), .nvm_security_strap_i(st[18]), .lan_power_state_strap_i(st[19]),
      .supply_mode_strap_i(st[20]), .boot_serial_o(mo[0]), .cipher_suite_en_o(mo[3]),
      .descriptor_security_en_o(mo[4]), .watchdog_reboot_en_o(mo[5]), .self_test_en_o(mo[7]),
      .service_boot_o(mo[8]), .trusted_platform_o(mo[9]), .trusted_agent_o(mo[10]), .safe_boot_o(mo[11]),
      .debug_mode_o(mo[12]), .mem_ddr4_o(mo[13]), .socket_id_o(sid), .lan_port0_en_o(mo[14]), .lan_port1_en_o(mo[15]),
      .manageability_en_o(mo[17]), .nvm_security_en_o(mo[18]), .lan_s5_avail_o(mo[19]), .combined_supply_o(mo[20]));
   strap_board_model strap_board_model_inst (.alt_i(alt), .pin_drv_i(pad_o), .pin_oe_i(pad_oe_o), .pull_i(pull),
      .strap_o(st), .pin_o(pad_i));
   // mode pins gathered in status order; status bits with no pin of their own read 0
   assign {mo[22:21], mo[16], mo[6], mo[2:1]} = {strap_valid_o, mgmt_serdes_mode_o, 3'h0, boot_lpc_o};
   always #25 core_clk_i = ~core_clk_i;
   ////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      if (miscompares == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : tally_and_finish
   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      compares++;
      if (s !== x) begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, x);
      end
   endtask : chk
   // two spare edges so registered pin and mode outputs have landed on return
   task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic e);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge core_clk_i) penable_i <= 1'b1;
      do @(posedge core_clk_i); while (pready_o !== 1'b1);
      r = prdata_o;
      e = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
   endtask : xfer
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      xfer(1'b1, a, d, r, e);
   endtask : wr
   task automatic rdc(input logic [15:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic        e;
      xfer(1'b0, a, 32'h0, r, e);
      chk(r, x);
   endtask : rdc
   task automatic do_reset(input logic a);
      alt <= a;
      resetn_i <= 1'b0;
      repeat (20) @(posedge core_clk_i);
      resetn_i <= 1'b1;
      do @(posedge core_clk_i); while (strap_valid_o !== 1'b1);
   endtask : do_reset
   ////////////////////////////////////////////////////////////////////////////
   // mode words decoded by hand from the board fit and its inverse
   initial begin
      logic [31:0] r;
      logic        e;
      do_reset(1'b0);
      rdc(OFS_MODE_STAT, 32'h007A_E931);
      chk({9'h0, mo}, 32'h007A_E931);
      chk({29'h0, sid}, 32'h0);
      rdc(OFS_BOOT_DEST, 32'h0000_0C00);
      chk({27'h0, top_swap_mask_o}, 32'h0);
      chk({31'h0, mgmt_serdes_mode_o}, 32'h1);
      alt <= 1'b1;
      wr(OFS_STRAP_RAW, 32'h0);
      rdc(OFS_STRAP_RAW, {11'h0, FIT});
      chk({9'h0, mo}, 32'h007A_E931);
      wr(OFS_BOOT_DEST, 32'h0);
      chk({31'h0, boot_lpc_o}, 32'h1);
      rdc(OFS_BOOT_DEST, 32'h0);
      pstrb_i <= 4'h1;
      wr(OFS_BOOT_DEST, 32'h0000_0C00);
      pstrb_i <= 4'hF;
      rdc(OFS_BOOT_DEST, 32'h0);
      xfer(1'b0, 16'h0020, 32'h0, r, e);
      chk({31'h0, e}, 32'h1);
      wr(OFS_PIN_DIR, 32'h0);
      chk(pad_oe_o, 32'h0000_FFFF);
      chk(pad_o, 32'h3C3C_5A5A);
      wr(OFS_PIN_USE, 32'hFFFF_0000);
      wr(OFS_PIN_OUT, 32'hA5A5_0000);
      wr(OFS_PIN_DIR, 32'h00FF_0000);
      chk(pad_oe_o, 32'hFF00_FFFF);
      chk(pad_o, 32'hA5A5_5A5A);
      chk(native_in_o, 32'h0000_5A5A);
      rdc(OFS_PIN_IN, 32'hA50F_0000);
      do_reset(1'b1);
      rdc(OFS_MODE_STAT, 32'h0064_16CA);
      chk({9'h0, mo}, 32'h0064_168A);
      chk({29'h0, sid}, 32'h7);
      rdc(OFS_STRAP_RAW, {11'h0, ~FIT});
      wr(OFS_MODE_CFG, 32'h0000_0004);
      chk({27'h0, top_swap_mask_o}, 32'h0000_0004);
      chk({31'h0, mgmt_serdes_mode_o}, 32'h0);
      tally_and_finish();
   end
endmodule : testbench
